// ===== cddp_consts.svh
`ifndef CDDP_CONSTS_SVH
`define CDDP_CONSTS_SVH
`define CDDP_IDX_OUT6_BYP 9'h0A0
`define CDDP_IDX_OUT6_DELAY_RAMP 9'h0A1
`define CDDP_IDX_OUT6_FRAC 9'h0A2
`define CDDP_IDX_OUT7_BYP 9'h0A3
`define CDDP_IDX_OUT7_DELAY_RAMP 9'h0A4
`define CDDP_IDX_OUT7_FRAC 9'h0A5
`define CDDP_IDX_OUT8_BYP 9'h0A6
`define CDDP_IDX_OUT8_DELAY_RAMP 9'h0A7
`define CDDP_IDX_OUT8_FRAC 9'h0A8
`define CDDP_IDX_OUT9_BYP 9'h0A9
`define CDDP_IDX_OUT9_DELAY_RAMP 9'h0AA
`define CDDP_IDX_OUT9_FRAC 9'h0AB
`define CDDP_IDX_CH3_S1_CYC 9'h199
`define CDDP_IDX_CH3_PHASE 9'h19A
`define CDDP_IDX_CH3_S2_CYC 9'h19B
`define CDDP_IDX_CH3_START 9'h19C
`define CDDP_IDX_CH4_S1_CYC 9'h19E
`define CDDP_IDX_CH4_PHASE 9'h19F
`define CDDP_IDX_CH4_S2_CYC 9'h1A0
`define CDDP_IDX_CH4_START 9'h1A1
`define CDDP_IDX_CONTROL 9'h1B0
`define CDDP_IDX_STATUS 9'h1B1
`define CDDP_IDX_RAMP67 9'h1B2
`define CDDP_IDX_RAMP89 9'h1B3
`define CDDP_HIGH_LSB 0
`define CDDP_LOW_LSB 4
`define CDDP_PO_S1_LSB 0
`define CDDP_PO_S2_LSB 4
`define CDDP_SH_S1_BIT 0
`define CDDP_SH_S2_BIT 1
`define CDDP_DBYP_BIT 0
`define CDDP_RCUR_LSB 3
`define CDDP_RCAP_LSB 0
`define CDDP_FRAC_LSB 0
`define CDDP_CTL_DCCDIS_LSB 0
`define CDDP_CTL_NOSYNC_LSB 2
`define CDDP_CTL_SOFT_SYNC 4
`define CDDP_CTL_SBYP_LSB 8
`define CDDP_REG_RST 8'h00
`define CDDP_CTL_RST 16'h0000
`define CDDP_PIN_RST 2'h2
`define CDDP_PHASE_WRAP 6'h10
`define CDDP_RAMP_STEP_UA 11'h0C8
`define CDDP_FRAC_MAX 6'h2F
`define CDDP_RESP_OKAY 2'h0
`define CDDP_RESP_SLVERR 2'h2
`endif

// ===== cddp_fdelay.sv
`timescale 1ns/1ns
module cddp_fdelay #(
	parameter int FRAC_W = 6
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_in,
	input wire logic bypass,
	input wire logic [FRAC_W-1:0] fraction,
	output logic clk_out,
	output logic stopped
);
	localparam int DEPTH = 1 << FRAC_W;
	logic [DEPTH-1:0] hist;
	logic [7:0] run_len;
	logic [7:0] half_len;
	logic prev;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			hist <= '0;
		else
			hist <= {hist[DEPTH-2:0], clk_in};
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			prev <= 1'b0;
			run_len <= 8'h01;
			half_len <= 8'hFF;
		end
		else
		begin
			prev <= clk_in;
			if (clk_in != prev)
			begin
				half_len <= run_len;
				run_len <= 8'h01;
			end
			else if (run_len != 8'hFF)
				run_len <= run_len + 8'h01;
		end
	end

	// The delay is counted in bus clocks; a delay of half the period or more cannot be honoured.
	assign stopped = !bypass && (8'(fraction) >= half_len); // see [RULE14] [RULE15]

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			clk_out <= 1'b0;
		else if (bypass)
			clk_out <= clk_in; // see [RULE18]
		else if (stopped)
			clk_out <= 1'b0; // see [RULE15]
		else
			clk_out <= hist[fraction]; // see [RULE13]
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_stop_quiet: assert property (stopped |=> !clk_out) // see [RULE15]
		else $error("stopped output still toggles");
	a_byp_route: assert property (bypass ##1 bypass |-> clk_out == $past(clk_in)) // see [RULE18]
		else $error("bypass does not route around delay");
endmodule // cddp_fdelay

// ===== cddp_pkg.sv
`include "cddp_consts.svh"
package cddp_pkg;
	typedef enum logic [2:0] {CDDP_HOLD = 3'h1, CDDP_WAIT = 3'h2, CDDP_RUN = 3'h4} cddp_state_e;

	function automatic logic [5:0] cddp_phase_delay(input logic sh, input logic [3:0] po,
		input logic [3:0] low);
		logic [5:0] phi;
		phi = {1'b0, sh, po};
		if (phi < `CDDP_PHASE_WRAP)
			return phi;
		return 6'(phi - `CDDP_PHASE_WRAP + {2'h0, low} + 6'h01);
	endfunction

	function automatic logic [10:0] cddp_ramp_ua(input logic [2:0] code);
		return 11'(({8'h00, code} + 11'h001) * `CDDP_RAMP_STEP_UA);
	endfunction

	function automatic logic [2:0] cddp_cap_count(input logic [2:0] f);
		return {2'h0, ~f[0]} + {2'h0, ~f[1]} + {2'h0, ~f[2]} + 3'h1;
	endfunction
endpackage

// ===== cddp_stage.sv
`timescale 1ns/1ns
`include "cddp_consts.svh"
module cddp_stage
	import cddp_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	cddp_stage_if.cfg_dst cfg,
	input wire logic hold,
	input wire logic in_level,
	input wire logic in_rise,
	input wire logic in_fall,
	output logic out_level,
	output logic out_rise,
	output logic out_fall
);
	cddp_state_e state;
	logic [4:0] cnt;
	logic [5:0] wait_cnt;
	logic [5:0] delay;
	logic [4:0] total_m1;
	logic odd_dcc;
	logic next_level;

	assign total_m1 = {1'b0, cfg.high_cnt} + {1'b0, cfg.low_cnt} + 5'h01; // see [RULE1]
	assign odd_dcc = cfg.dcc_on && ({1'b0, cfg.low_cnt} == {1'b0, cfg.high_cnt} + 5'h01); // see [RULE5]
	assign delay = cddp_phase_delay(cfg.start_level_flag, cfg.phase_offset_field, cfg.low_cnt); // see [RULE7]

	always_ff @(posedge aclk)
	begin
		if (!aresetn || hold)
		begin
			state <= CDDP_HOLD;
			cnt <= 5'h00;
			wait_cnt <= 6'h00;
		end
		else
		begin
			unique case (state)
				CDDP_HOLD: state <= CDDP_WAIT;
				CDDP_WAIT:
					if (in_rise)
					begin
						if (wait_cnt == delay) // see [RULE8] [RULE9]
						begin
							state <= CDDP_RUN;
							cnt <= 5'h00;
						end
						else
							wait_cnt <= wait_cnt + 6'h01;
					end
				CDDP_RUN:
					if (in_rise)
						cnt <= (cnt == total_m1) ? 5'h00 : cnt + 5'h01; // see [RULE1]
			endcase
		end
	end

	// An odd count under correction ends its high phase on an input falling edge.
	always_comb
	begin
		next_level = out_level;
		if (cfg.bypass)
			next_level = in_level; // see [RULE3]
		else if (hold)
			next_level = cfg.start_level_flag; // see [RULE17]
		else if (state == CDDP_WAIT && in_rise && wait_cnt == delay)
			next_level = 1'b1;
		else if (state == CDDP_RUN && in_rise)
		begin
			if (cnt == total_m1)
				next_level = 1'b1;
			else if (!odd_dcc && cnt == {1'b0, cfg.high_cnt})
				next_level = 1'b0; // see [RULE4]
		end
		else if (state == CDDP_RUN && in_fall && odd_dcc && cnt == {1'b0, cfg.high_cnt} + 5'h01)
			next_level = 1'b0; // see [RULE6]
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			out_level <= 1'b0;
			out_rise <= 1'b0;
			out_fall <= 1'b0;
		end
		else
		begin
			out_level <= next_level;
			out_rise <= next_level && !out_level;
			out_fall <= !next_level && out_level;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_wait_done;
		state == CDDP_WAIT && in_rise && wait_cnt == delay && !hold && !cfg.bypass;
	endsequence

	a_hold_level: assert property (hold && !cfg.bypass |=> out_level == $past(cfg.start_level_flag)) // see [RULE17]
		else $error("sync hold level differs from start flag");
	a_bypass_pass: assert property (cfg.bypass |=> out_level == $past(in_level)) // see [RULE3]
		else $error("bypassed stage does not follow input");
	a_phase_start: assert property (s_wait_done |=> state == CDDP_RUN && out_level && cnt == 5'h00) // see [RULE8]
		else $error("phase wait ended wrongly");
	a_odd_fall: assert property (!$past(hold) && !$past(cfg.bypass) && $past(state) == CDDP_RUN && $past(odd_dcc) && $fell(out_level) |-> $past(in_fall)) // see [RULE6]
		else $error("odd stage fell off an input falling edge");
	a_period_wrap: assert property (!$past(hold) && !$past(cfg.bypass) && $past(state) == CDDP_RUN && $rose(out_level) |-> $past(cnt) == $past(total_m1)) // see [RULE1]
		else $error("stage period is not high plus low plus two");
endmodule // cddp_stage

// ===== cddp_stage_if.sv
`timescale 1ns/1ns
interface cddp_stage_if;
	logic [3:0] high_cnt;
	logic [3:0] low_cnt;
	logic [3:0] phase_offset_field;
	logic start_level_flag;
	logic bypass;
	logic dcc_on;
	modport cfg_src (output high_cnt, low_cnt, phase_offset_field, start_level_flag, bypass,
		dcc_on);
	modport cfg_dst (input high_cnt, low_cnt, phase_offset_field, start_level_flag, bypass,
		dcc_on);
endinterface

// ===== cddp_top.sv
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "cddp_consts.svh"
// What this block does
// [RULE1] Stage divides by high plus low plus two.
// [RULE2] Hold start, phase, low, high per stage.
// [RULE3] Bypassed stages with correction pass input duty.
// [RULE4] Equal counts with correction give half duty.
// [RULE5] Odd division needs low one above high.
// [RULE6] Odd first stage high fraction tracks input.
// [RULE7] Phase count is sixteen start plus offset.
// [RULE8] Phase up to 15 delays that many periods.
// [RULE9] Larger phase adds low count; stages add.
// [RULE10] Each fine delay output has four fields.
// [RULE11] Ramp current is 200 uA times code+1.
// [RULE12] Capacitors equal zero bits plus one.
// [RULE13] Software keeps delay fraction at most 47.
// [RULE14] Software keeps delay within half period.
// [RULE15] Too long a fine delay stops output.
// [RULE16] Correction disable bit turns correction off.
// [RULE17] Sync applies start level and phase offset.
// [RULE18] Delay bypass routes clock around delay.
module cddp_top
	import cddp_pkg::*;
#(
	parameter int FRAC_W = 6
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	input wire logic dist_clk,
	input wire logic sync_n,
	output logic [3:0] out_clk
);
	localparam logic [4:0] SLOT_DIV = 5'h0C;
	localparam logic [4:0] SLOT_CH4 = 5'h10;
	localparam logic [4:0] SLOT_CTL = 5'h14;
	localparam logic [4:0] SLOT_STAT = 5'h15;
	localparam logic [4:0] SLOT_R67 = 5'h16;
	localparam logic [4:0] SLOT_R89 = 5'h17;
	localparam int NCFG = 20;

	logic [7:0] cfg [NCFG];
	logic [15:0] ctl;
	logic [1:0] pin_a;
	logic [1:0] pin_b;
	logic [1:0] pin_c;
	logic [1:0] pin_lvl;
	logic [1:0] next_pin;
	logic dist_rise;
	logic dist_fall;
	logic aw_held;
	logic w_held;
	logic [11:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	logic [5:0] wr_slot;
	logic [5:0] rd_slot;
	logic [31:0] rd_data;
	logic [1:0] rd_resp;
	logic sync_req;
	logic [1:0] hold;
	logic [3:0] in_lvl;
	logic [3:0] in_rise;
	logic [3:0] in_fall;
	logic [3:0] st_level;
	logic [3:0] st_rise;
	logic [3:0] st_fall;
	logic [3:0] stopped;
	logic [3:0] frac_over;
	logic [11:0] caps;
	logic [43:0] ramp_ua;

	// Register indices are word numbers; the byte address is four times the index.
	function automatic logic [5:0] reg_slot(input logic [11:0] addr);
		logic [8:0] idx;
		logic [5:0] s;
		idx = addr[10:2];
		s = 6'h00;
		if (idx >= `CDDP_IDX_OUT6_BYP && idx <= `CDDP_IDX_OUT9_FRAC)
			s = {1'b1, 5'(idx - `CDDP_IDX_OUT6_BYP)};
		else if (idx >= `CDDP_IDX_CH3_S1_CYC && idx <= `CDDP_IDX_CH3_START)
			s = {1'b1, SLOT_DIV + 5'(idx - `CDDP_IDX_CH3_S1_CYC)};
		else if (idx >= `CDDP_IDX_CH4_S1_CYC && idx <= `CDDP_IDX_CH4_START)
			s = {1'b1, SLOT_CH4 + 5'(idx - `CDDP_IDX_CH4_S1_CYC)};
		else if (idx == `CDDP_IDX_CONTROL)
			s = {1'b1, SLOT_CTL};
		else if (idx == `CDDP_IDX_STATUS)
			s = {1'b1, SLOT_STAT};
		else if (idx == `CDDP_IDX_RAMP67)
			s = {1'b1, SLOT_R67};
		else if (idx == `CDDP_IDX_RAMP89)
			s = {1'b1, SLOT_R89};
		if (addr[11])
			s = 6'h00;
		return s;
	endfunction

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pin_a <= `CDDP_PIN_RST;
			pin_b <= `CDDP_PIN_RST;
			pin_c <= `CDDP_PIN_RST;
		end
		else
		begin
			pin_a <= {sync_n, dist_clk};
			pin_b <= pin_a;
			pin_c <= pin_b;
		end
	end

	// A pin level is taken only when the last two stages agree, so a late sample never glitches.
	assign next_pin = (pin_b & pin_c) | (pin_lvl & (pin_b ^ pin_c));

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pin_lvl <= `CDDP_PIN_RST;
			dist_rise <= 1'b0;
			dist_fall <= 1'b0;
		end
		else
		begin
			pin_lvl <= next_pin;
			dist_rise <= next_pin[0] && !pin_lvl[0];
			dist_fall <= !next_pin[0] && pin_lvl[0];
		end
	end

	assign sync_req = !pin_lvl[1] || ctl[`CDDP_CTL_SOFT_SYNC];

	cddp_stage_if st_if [4] ();

	for (genvar c = 0; c < 2; c++)
	begin : g_ch
		assign hold[c] = sync_req && !ctl[`CDDP_CTL_NOSYNC_LSB + c]; // see [RULE17]
		for (genvar s = 0; s < 2; s++)
		begin : g_st
			localparam int K = 2 * c + s;
			localparam int CYC = int'(SLOT_DIV) + 4 * c + 2 * s;
			localparam int PH = int'(SLOT_DIV) + 4 * c + 1;
			localparam int SH = int'(SLOT_DIV) + 4 * c + 3;
			localparam int POL = (s == 0) ? `CDDP_PO_S1_LSB : `CDDP_PO_S2_LSB;
			localparam int SHB = (s == 0) ? `CDDP_SH_S1_BIT : `CDDP_SH_S2_BIT;
			assign st_if[K].high_cnt = cfg[CYC][`CDDP_HIGH_LSB +: 4]; // see [RULE2]
			assign st_if[K].low_cnt = cfg[CYC][`CDDP_LOW_LSB +: 4];
			assign st_if[K].phase_offset_field = cfg[PH][POL +: 4];
			assign st_if[K].start_level_flag = cfg[SH][SHB];
			assign st_if[K].bypass = ctl[`CDDP_CTL_SBYP_LSB + K];
			assign st_if[K].dcc_on = !ctl[`CDDP_CTL_DCCDIS_LSB + c]; // see [RULE16]
			if (s == 0)
			begin : g_in
				assign in_lvl[K] = pin_lvl[0];
				assign in_rise[K] = dist_rise;
				assign in_fall[K] = dist_fall;
			end
			else
			begin : g_in
				// The second stage is clocked by the first, so the phase delays add.
				assign in_lvl[K] = st_level[K-1]; // see [RULE9]
				assign in_rise[K] = st_rise[K-1];
				assign in_fall[K] = st_fall[K-1];
			end
			cddp_stage u_stage (
				.aclk (aclk),
				.aresetn (aresetn),
				.cfg (st_if[K]),
				.hold (hold[c]),
				.in_level (in_lvl[K]),
				.in_rise (in_rise[K]),
				.in_fall (in_fall[K]),
				.out_level (st_level[K]),
				.out_rise (st_rise[K]),
				.out_fall (st_fall[K])
			);
		end
	end

	for (genvar k = 0; k < 4; k++)
	begin : g_out
		localparam int B = 3 * k;
		assign caps[3*k +: 3] = cddp_cap_count(cfg[B+1][`CDDP_RCAP_LSB +: 3]); // see [RULE12]
		assign ramp_ua[11*k +: 11] = cddp_ramp_ua(cfg[B+1][`CDDP_RCUR_LSB +: 3]); // see [RULE11]
		assign frac_over[k] = cfg[B+2][`CDDP_FRAC_LSB +: 6] > `CDDP_FRAC_MAX; // see [RULE13]
		cddp_fdelay #(
			.FRAC_W (FRAC_W)
		) u_fdelay (
			.aclk (aclk),
			.aresetn (aresetn),
			.clk_in (st_level[2*(k/2)+1]),
			.bypass (cfg[B][`CDDP_DBYP_BIT]), // see [RULE10]
			.fraction (cfg[B+2][`CDDP_FRAC_LSB +: FRAC_W]),
			.clk_out (out_clk[k]),
			.stopped (stopped[k])
		);
	end

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign do_write = aw_held && w_held && !s_axi_bvalid;
	assign wr_slot = reg_slot(aw_addr);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			aw_addr <= 12'h000;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end
		else if (do_write)
			aw_held <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_held <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end
		else if (do_write)
			w_held <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `CDDP_RESP_OKAY;
		end
		else if (do_write)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (wr_slot[5] && wr_slot[4:0] <= SLOT_CTL) ?
				`CDDP_RESP_OKAY : `CDDP_RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < NCFG; i++)
				cfg[i] <= `CDDP_REG_RST;
		end
		else if (do_write && wr_slot[5] && wr_slot[4:0] < SLOT_CTL && w_strb[0])
			cfg[wr_slot[4:0]] <= w_data[7:0]; // see [RULE2] [RULE10]
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ctl <= `CDDP_CTL_RST;
		else if (do_write && wr_slot == {1'b1, SLOT_CTL})
		begin
			if (w_strb[0])
				ctl[7:0] <= w_data[7:0];
			if (w_strb[1])
				ctl[15:8] <= w_data[15:8];
		end
	end

	assign s_axi_arready = !s_axi_rvalid;
	assign rd_slot = reg_slot(s_axi_araddr);

	always_comb
	begin
		rd_data = 32'h00000000;
		rd_resp = `CDDP_RESP_OKAY;
		if (!rd_slot[5])
			rd_resp = `CDDP_RESP_SLVERR;
		else if (rd_slot[4:0] < SLOT_CTL)
			rd_data = {24'h000000, cfg[rd_slot[4:0]]};
		else
		begin
			unique case (rd_slot[4:0])
				SLOT_CTL: rd_data = {16'h0000, ctl};
				SLOT_STAT: rd_data = {10'h000, hold, caps, frac_over, stopped};
				SLOT_R67: rd_data = {5'h00, ramp_ua[21:11], 5'h00, ramp_ua[10:0]};
				SLOT_R89: rd_data = {5'h00, ramp_ua[43:33], 5'h00, ramp_ua[32:22]};
				default: rd_resp = `CDDP_RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `CDDP_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_data;
			s_axi_rresp <= rd_resp;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_bus_refuse: assert property (do_write && !wr_slot[5] |=> s_axi_bvalid && s_axi_bresp == `CDDP_RESP_SLVERR)
		else $error("unmapped write was not refused");
	a_dcc_write: assert property (do_write && wr_slot == {1'b1, SLOT_CTL} && w_strb[0] |=> st_if[0].dcc_on == !$past(w_data[`CDDP_CTL_DCCDIS_LSB])) // see [RULE16]
		else $error("correction disable bit not applied");
	a_phase_write: assert property (do_write && wr_slot == {1'b1, SLOT_DIV + 5'h01} && w_strb[0] |=> st_if[1].phase_offset_field == $past(w_data[`CDDP_PO_S2_LSB +: 4])) // see [RULE2]
		else $error("second stage phase offset not stored");
	a_ramp_read: assert property (s_axi_arvalid && s_axi_arready && rd_slot == {1'b1, SLOT_R67} |=> s_axi_rdata[10:0] == 11'(({8'h00, $past(cfg[1][`CDDP_RCUR_LSB +: 3])} + 11'h001) * `CDDP_RAMP_STEP_UA)) // see [RULE11]
		else $error("ramp current readback wrong");
	a_caps_read: assert property (s_axi_arvalid && s_axi_arready && rd_slot == {1'b1, SLOT_STAT} |=> s_axi_rdata[10:8] == 3'($countones(~$past(cfg[1][2:0]))) + 3'h1) // see [RULE12]
		else $error("capacitor count readback wrong");
endmodule // cddp_top

// ===== tb_top.sv
`timescale 1ns/1ns
`include "cddp_consts.svh"
module tb_top
	import cddp_pkg::*;
;
	logic aclk, aresetn, awv, awr, wv, wr, bv, br, arv, arr, rv, rr, dist_clk, sync_n;
	logic [11:0] awa, ara;
	logic [31:0] wd, rd;
	logic [1:0] bresp, rresp;
	logic [3:0] oc;
	int failures, n_compared, cyc, dc_cnt, hi_len, lo_len;

	cddp_top i_cddp_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_wvalid(wv),
		.s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv),
		.s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_rvalid(rv), .s_axi_rready(rr),
		.s_axi_rdata(rd), .s_axi_rresp(rresp), .dist_clk(dist_clk), .sync_n(sync_n),
		.out_clk(oc));

	always #50 aclk = ~aclk;
	always @(posedge aclk) cyc <= cyc + 1;
	// The divider input is made in step with aclk so that edge counts come out exact.
	always @(posedge aclk)
	begin
		if (dc_cnt + 1 >= (dist_clk ? hi_len : lo_len))
		begin
			dist_clk <= !dist_clk;
			dc_cnt <= 0;
		end
		else
			dc_cnt <= dc_cnt + 1;
	end

	task test_done;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task tmo;
		failures++;
		$display("BAD %0t wait ran out", $time);
		test_done();
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_compared++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD %0t %s got %h expected %h", $time, m, got, exp);
		end
	endtask

	function automatic logic [11:0] ba(input logic [8:0] i);
		return {1'b0, i, 2'b00};
	endfunction

	task automatic bw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		logic pa, pw, ha, hw;
		int n;
		@(posedge aclk);
		awv <= 1'b1;
		awa <= a;
		wv <= 1'b1;
		wd <= d;
		br <= 1'b1;
		pa = 1'b1;
		pw = 1'b1;
		n = 0;
		while ((pa || pw) && n < 50)
		begin
			@(negedge aclk);
			ha = pa && awr;
			hw = pw && wr;
			@(posedge aclk);
			if (ha)
			begin
				pa = 1'b0;
				awv <= 1'b0;
			end
			if (hw)
			begin
				pw = 1'b0;
				wv <= 1'b0;
			end
			n++;
		end
		do
		begin
			@(negedge aclk);
			n++;
		end
		while (bv !== 1'b1 && n < 100);
		if (n >= 100) tmo();
		r = bresp;
		@(posedge aclk);
		br <= 1'b0;
	endtask

	task automatic brd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		arv <= 1'b1;
		ara <= a;
		rr <= 1'b1;
		n = 0;
		do
		begin
			@(negedge aclk);
			n++;
		end
		while (arr !== 1'b1 && n < 50);
		@(posedge aclk);
		arv <= 1'b0;
		do
		begin
			@(negedge aclk);
			n++;
		end
		while (rv !== 1'b1 && n < 100);
		if (n >= 100) tmo();
		d = rd;
		r = rresp;
		@(posedge aclk);
		rr <= 1'b0;
	endtask

	task automatic wr8(input logic [8:0] i, input logic [31:0] d);
		logic [1:0] r;
		bw(ba(i), d, r);
		chk(32'(r), 32'(`CDDP_RESP_OKAY), "write response");
	endtask

	task automatic rd8(input logic [8:0] i, output logic [31:0] d);
		logic [1:0] r;
		brd(ba(i), d, r);
		chk(32'(r), 32'(`CDDP_RESP_OKAY), "read response");
	endtask

	task automatic ew(input int i, input logic lv, output int t);
		int n;
		n = 0;
		do
		begin
			@(negedge aclk);
			n++;
		end
		while (oc[i] !== lv && n < 400);
		if (n >= 400) tmo();
		t = cyc;
	endtask

	task automatic meas(input int i, output int hi, output int per);
		int a, b, c;
		ew(i, 1'b0, a);
		ew(i, 1'b1, a);
		ew(i, 1'b0, b);
		ew(i, 1'b1, c);
		hi = b - a;
		per = c - a;
	endtask

	task automatic t_regs;
		logic [31:0] d;
		logic [1:0] r;
		logic [8:0] ix;
		logic [7:0] v;
		for (int k = 0; k < 21; k++)
		begin
			ix = (k < 12) ? 9'(9'h0A0 + k) : 9'(9'h199 + k - 12);
			v = (k >= 12) ? 8'hA5 : (k % 3 == 0) ? 8'h01 : (k % 3 == 1) ? 8'h2D : 8'h2A;
			if (ix == 9'h19D) continue;
			rd8(ix, d);
			chk(d, 32'h0, "config reset value");
			wr8(ix, {24'h0, v});
			rd8(ix, d);
			chk(d, {24'h0, v}, "config readback");
			wr8(ix, 32'h0);
		end
		wr8(`CDDP_IDX_OUT6_DELAY_RAMP, 32'h1C);
		rd8(`CDDP_IDX_RAMP67, d);
		chk({21'h0, d[10:0]}, 32'd800, "ramp current");
		rd8(`CDDP_IDX_STATUS, d);
		chk({29'h0, d[10:8]}, 32'd3, "capacitor count");
		wr8(`CDDP_IDX_OUT6_DELAY_RAMP, 32'h0);
		bw(12'h800, 32'h1, r);
		chk(32'(r), 32'(`CDDP_RESP_SLVERR), "unmapped write");
		brd(12'h800, d, r);
		chk({d[29:0], r}, 32'(`CDDP_RESP_SLVERR), "unmapped read");
		bw(ba(`CDDP_IDX_STATUS), 32'h1, r);
		chk(32'(r), 32'(`CDDP_RESP_SLVERR), "read-only write");
		$display("register test done");
	endtask

	task automatic t_duty;
		// Columns: high, low, dcc off, stage1 bypass, in high, in low, out high, out period.
		int tb[5][8] = '{'{1, 1, 0, 0, 6, 10, 32, 64}, '{1, 2, 0, 0, 8, 8, 40, 80},
			'{1, 2, 0, 0, 6, 10, 38, 80}, '{1, 2, 1, 0, 6, 10, 32, 80},
			'{0, 0, 0, 1, 6, 10, 6, 16}};
		int hi, per;
		wr8(`CDDP_IDX_OUT7_BYP, 32'h1);
		for (int k = 0; k < 5; k++)
		begin
			hi_len = tb[k][4];
			lo_len = tb[k][5];
			wr8(`CDDP_IDX_CH3_S1_CYC, 32'(tb[k][1] * 16 + tb[k][0]));
			wr8(`CDDP_IDX_CONTROL, 32'((tb[k][3] << 8) | 32'h200 | tb[k][2]));
			meas(1, hi, per);
			meas(1, hi, per);
			chk(32'(per), 32'(tb[k][7]), "divided period");
			chk(32'(hi), 32'(tb[k][6]), "high time");
		end
		$display("duty test done");
	endtask

	task automatic t_phase;
		int sh, po, phi, t3, t4;
		hi_len = 8;
		lo_len = 8;
		wr8(`CDDP_IDX_CONTROL, 32'hA00);
		wr8(`CDDP_IDX_CH3_S1_CYC, 32'h11);
		wr8(`CDDP_IDX_CH4_S1_CYC, 32'h11);
		wr8(`CDDP_IDX_OUT9_BYP, 32'h1);
		for (int k = 0; k < 2; k++)
		begin
			sh = k;
			po = (k == 0) ? 5 : 1;
			phi = 16 * sh + po;
			wr8(`CDDP_IDX_CH3_PHASE, 32'(po));
			wr8(`CDDP_IDX_CH3_START, 32'(sh));
			@(posedge aclk);
			sync_n <= 1'b0;
			repeat (60) @(posedge aclk);
			@(negedge aclk);
			chk({31'h0, oc[1]}, 32'(sh), "held start level");
			@(posedge aclk);
			sync_n <= 1'b1;
			ew(3, 1'b1, t4);
			ew(3, 1'b0, t4);
			ew(1, 1'b1, t3);
			ew(1, 1'b0, t3);
			// Both stages use a low count of one here.
			chk(32'(t3 - t4), 32'(16 * (phi <= 15 ? phi : phi - 16 + 1 + 1)),
				"coarse phase delay");
		end
		wr8(`CDDP_IDX_CH3_START, 32'h0);
		$display("phase test done");
	endtask

	task automatic t_fine;
		logic [31:0] d;
		int t0, t1, hi;
		wr8(`CDDP_IDX_OUT6_FRAC, 32'h5);
		wr8(`CDDP_IDX_OUT6_BYP, 32'h0);
		meas(1, hi, t0);
		ew(1, 1'b0, t1);
		ew(1, 1'b1, t1);
		ew(0, 1'b1, t0);
		chk(32'(t0 - t1), 32'd6, "fine delay against bypass");
		// Beyond the half period of 32 cycles yet still a supported fraction.
		wr8(`CDDP_IDX_OUT6_FRAC, 32'(`CDDP_FRAC_MAX));
		repeat (300) @(posedge aclk);
		rd8(`CDDP_IDX_STATUS, d);
		chk({31'h0, d[0]}, 32'h1, "stopped flag");
		wr8(`CDDP_IDX_OUT8_FRAC, 32'h30);
		rd8(`CDDP_IDX_STATUS, d);
		chk({31'h0, d[6]}, 32'h1, "fraction over flag");
		hi = 0;
		repeat (200)
		begin
			@(negedge aclk);
			if (oc[0] !== 1'b0) hi++;
		end
		chk(32'(hi), 32'h0, "stopped output");
		$display("fine delay test done");
	endtask

	initial
	begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{awv, wv, br, arv, rr} = 5'h00;
		awa = 12'h000;
		ara = 12'h000;
		wd = 32'h0;
		dist_clk = 1'b0;
		sync_n = 1'b1;
		{failures, n_compared, cyc, dc_cnt} = {32'd0, 32'd0, 32'd0, 32'd0};
		hi_len = 8;
		lo_len = 8;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_duty();
		t_phase();
		t_fine();
		test_done();
	end
endmodule // tb_top
